/* core/todai_defines.svh */
`ifndef TODAI_DEFINES_SVH
`define TODAI_DEFINES_SVH

// Register offsets in the special-function space
`define TODAI_ADDR_EXT_INT_ENABLE      8'he8
`define TODAI_ADDR_ALARM_SUBSECOND     8'hf2
`define TODAI_ADDR_ALARM_SECOND        8'hf3
`define TODAI_ADDR_ALARM_MINUTE        8'hf4
`define TODAI_ADDR_ALARM_HOUR          8'hf5
`define TODAI_ADDR_EXT_INT_PRIORITY    8'hf8
`define TODAI_ADDR_TIME_OF_DAY_CONTROL 8'hf9

// Interrupt source positions in enable and priority registers
`define TODAI_SRC_TOD       5
`define TODAI_SRC_WATCHDOG  4
`define TODAI_NUM_SRC       6
`define TODAI_NUM_PINS      4

// Control register fields
`define TODAI_CTL_SUBSEC_CE  7
`define TODAI_CTL_SEC_CE     6
`define TODAI_CTL_MIN_CE     5
`define TODAI_CTL_HOUR_CE    4
`define TODAI_CTL_READ_EN    3
`define TODAI_CTL_WRITE_EN   2
`define TODAI_CTL_IRQ_FLAG   1
`define TODAI_CTL_OSC_EN     0

// Implemented widths of the alarm fields
`define TODAI_SUBSEC_W  8
`define TODAI_SEC_W     6
`define TODAI_MIN_W     6
`define TODAI_HOUR_W    5

// Reset values
`define TODAI_EXT_INT_ENABLE_RST   6'h00
`define TODAI_EXT_INT_PRIORITY_RST 6'h00

// Access window auto-close time
`define TODAI_CLK_PERIOD_NS   4
`define TODAI_WIN_TIME_NS     1950000
`define TODAI_WIN_CYCLES      (`TODAI_WIN_TIME_NS / `TODAI_CLK_PERIOD_NS)
`define TODAI_WIN_CNT_W       19

`endif

/* core/todai_pkg.sv */
package todai_pkg;

	// Live clock counters fed from the time-of-day block
	typedef struct packed {
		logic [7:0] subsecond;
		logic [5:0] second;
		logic [5:0] minute;
		logic [7:0] hour;
	} todai_tod_count_type;

	// Interrupt decision handed to the core
	typedef struct packed {
		logic       pending;
		logic       highPrio;
		logic [2:0] source;
	} todai_irq_type;

	// Clock-register access window
	typedef enum logic [2:0] {
		WIN_IDLE  = 3'b001,
		WIN_READ  = 3'b010,
		WIN_WRITE = 3'b100
	} todai_win_type;

endpackage : todai_pkg

/* core/todai_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "todai_defines.svh"

// What this block does
// - Clock-alarm request passes only when enable bit 5 is set; reads 0 without clock.
// - Watchdog request passes only when enable bit 4 is set.
// - Enable bits 3..0 gate external pins 5, 4, 3, 2.
// - Enable register bits 7 and 6 are reserved, content undefined.
// - Priority bit 5 makes clock alarm high priority; reads 0 without clock.
// - Priority bit 4 makes watchdog interrupt high priority.
// - Priority bits 3..0 select high priority for external pins 5, 4, 3, 2.
// - Unused upper bits of priority and alarm registers read 0.
// - Subsecond alarm compare counts only when control bit 7 is set.
// - Second alarm compare counts only when control bit 6 is set.
// - Minute alarm compare counts only when control bit 5 is set.
// - Hour alarm compare gated by control bit 4; software loads 0 to 17h.
// - Day-of-week bits of the hour counter never join the comparison.
// - Alarm contents survive all resets except the no-battery reset.
// - Flag sets when at least one alarm field is enabled and every enabled field matches its counter.
// - Flag raises interrupt only with enable bit; clearing all enables clears it.
module todai_regs
	import todai_pkg::*;
#(
	parameter int unsigned WIN_CYCLES = `TODAI_WIN_CYCLES
) (
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                batteryRst_n,
	input  wire logic                ce,
	input  wire logic                todPresent,
	input  wire logic [7:0]          sfrAddr,
	input  wire logic                sfrWrEn,
	input  wire logic [7:0]          sfrWrData,
	input  wire logic                sfrRdEn,
	input  wire logic                timedAccessOk,
	output logic [7:0]               sfrRdData,
	output logic                     sfrRdHit,
	input  wire todai_tod_count_type todCount,
	input  wire logic                watchdogIrqReq,
	input  wire logic [3:0]          extIrqPin,
	output todai_irq_type            irqOut,
	output logic                     todReadEnable,
	output logic                     todWriteEnable,
	output logic                     todOscillatorEnable,
	output logic                     subsecondClear
);

	logic [5:0]          extIntEnable_q;
	logic [5:0]          extIntPriority_q;
	logic [7:0]          alarmSubsecond_q;
	logic [5:0]          alarmSecond_q;
	logic [5:0]          alarmMinute_q;
	logic [4:0]          alarmHour_q;
	logic [3:0]          compareEnable_q;
	logic                todIrqFlag_q;
	logic                todOscillatorEnable_q;
	todai_win_type       win_q;
	todai_win_type       win_d;
	logic [`TODAI_WIN_CNT_W-1:0] winCnt_q;
	logic                todPresent_q;
	logic [3:0]          pinMeta_q;
	logic [3:0]          pinSync_q;
	logic                match;
	logic                matchPrev_q;
	todai_tod_count_type countPrev_q;
	logic                countMoved;
	logic [3:0]          fieldHit;
	logic [5:0]          enableView;
	logic [5:0]          priorityView;
	logic [5:0]          rawReq;
	logic [5:0]          gatedReq;
	logic [5:0]          highReq;
	logic [5:0]          lowReq;
	todai_irq_type       irq_d;
	logic [7:0]          rdData_d;
	logic                rdHit_d;
	logic                wrCtl;
	logic                winExpired;
	logic                flagSet;
	logic                flagClr;
	logic [7:0]          ctlView;

	localparam logic [`TODAI_WIN_CNT_W-1:0] WinLast =
		`TODAI_WIN_CNT_W'(WIN_CYCLES - 1);

	assign wrCtl = sfrWrEn && (sfrAddr == `TODAI_ADDR_TIME_OF_DAY_CONTROL);

	// Variant strap is caught while reset is held, so it stays stable afterwards
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			todPresent_q <= todPresent;
		end
	end

	// External pins are asynchronous to the core clock
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pinMeta_q <= 4'h0;
			pinSync_q <= 4'h0;
		end else if (ce) begin
			pinMeta_q <= extIrqPin;
			pinSync_q <= pinMeta_q;
		end
	end

	// Enable and priority registers follow the ordinary device reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			extIntEnable_q   <= `TODAI_EXT_INT_ENABLE_RST;
			extIntPriority_q <= `TODAI_EXT_INT_PRIORITY_RST;
		end else if (ce && sfrWrEn) begin
			if (sfrAddr == `TODAI_ADDR_EXT_INT_ENABLE) begin
				extIntEnable_q <= sfrWrData[5:0];
			end
			if (sfrAddr == `TODAI_ADDR_EXT_INT_PRIORITY) begin
				extIntPriority_q <= sfrWrData[5:0];
			end
		end
	end

	// Alarm fields only see the battery reset; device resets leave them alone
	always_ff @(posedge clk) begin
		if (!batteryRst_n) begin
			alarmSubsecond_q <= 8'h00;
			alarmSecond_q    <= 6'h00;
			alarmMinute_q    <= 6'h00;
			alarmHour_q      <= 5'h00;
		end else if (ce && sfrWrEn) begin
			case (sfrAddr)
				`TODAI_ADDR_ALARM_SUBSECOND: begin
					alarmSubsecond_q <= sfrWrData;
				end
				`TODAI_ADDR_ALARM_SECOND: begin
					alarmSecond_q <= sfrWrData[5:0];
				end
				`TODAI_ADDR_ALARM_MINUTE: begin
					alarmMinute_q <= sfrWrData[5:0];
				end
				`TODAI_ADDR_ALARM_HOUR: begin
					alarmHour_q <= sfrWrData[4:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Compare enables and oscillator enable are battery-backed too
	always_ff @(posedge clk) begin
		if (!batteryRst_n) begin
			compareEnable_q       <= 4'h0;
			todOscillatorEnable_q <= 1'b0;
		end else if (ce && wrCtl) begin
			compareEnable_q <= sfrWrData[`TODAI_CTL_SUBSEC_CE:`TODAI_CTL_HOUR_CE];
			if (timedAccessOk) begin
				todOscillatorEnable_q <= sfrWrData[`TODAI_CTL_OSC_EN];
			end
		end
	end

	// Each field compares only its implemented bits against the live counter
	assign fieldHit[3] = !compareEnable_q[3] ||
		(alarmSubsecond_q == todCount.subsecond);
	assign fieldHit[2] = !compareEnable_q[2] ||
		(alarmSecond_q == todCount.second);
	assign fieldHit[1] = !compareEnable_q[1] ||
		(alarmMinute_q == todCount.minute);
	// Day-of-week bits 7..5 of the hour counter are deliberately dropped
	assign fieldHit[0] = !compareEnable_q[0] ||
		(alarmHour_q == todCount.hour[4:0]);

	// With no field enabled there is nothing to match
	assign match = (|compareEnable_q) && (&fieldHit);

	// Fire once per counter tick while matching, so a don't-care field
	// yields one event per tick instead of a stuck request
	assign countMoved = (countPrev_q != todCount);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			matchPrev_q <= 1'b0;
			countPrev_q <= '0;
		end else if (ce) begin
			matchPrev_q <= match;
			countPrev_q <= todCount;
		end
	end

	assign flagSet = match && (!matchPrev_q || countMoved);
	// Software writes 0 to clear; writing 1 also clears when compare enables 7..4 are all written 0
	assign flagClr = wrCtl && (!sfrWrData[`TODAI_CTL_IRQ_FLAG] ||
		(sfrWrData[`TODAI_CTL_SUBSEC_CE:`TODAI_CTL_HOUR_CE] == 4'h0));

	always_ff @(posedge clk) begin
		if (!batteryRst_n) begin
			todIrqFlag_q <= 1'b0;
		end else if (ce) begin
			if (flagSet) begin
				todIrqFlag_q <= 1'b1;
			end else if (flagClr) begin
				todIrqFlag_q <= 1'b0;
			end
		end
	end

	// Access window: read and write enables are mutually exclusive
	always_comb begin
		win_d = win_q;
		case (win_q)
			WIN_IDLE: begin
				if (wrCtl) begin
					if (sfrWrData[`TODAI_CTL_READ_EN] && sfrWrData[`TODAI_CTL_WRITE_EN]) begin
						win_d = WIN_IDLE;
					end else if (sfrWrData[`TODAI_CTL_READ_EN]) begin
						win_d = WIN_READ;
					end else if (sfrWrData[`TODAI_CTL_WRITE_EN] && timedAccessOk) begin
						win_d = WIN_WRITE;
					end
				end
			end
			WIN_READ: begin
				if (winExpired || (wrCtl && !sfrWrData[`TODAI_CTL_READ_EN])) begin
					win_d = WIN_IDLE;
				end
			end
			WIN_WRITE: begin
				if (winExpired) begin
					win_d = WIN_IDLE;
				end else if (wrCtl && timedAccessOk &&
					!sfrWrData[`TODAI_CTL_WRITE_EN]) begin
					win_d = WIN_IDLE;
				end
			end
			default: begin
				win_d = WIN_IDLE;
			end
		endcase
	end

	assign winExpired = (winCnt_q == WinLast);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			win_q <= WIN_IDLE;
		end else if (ce) begin
			win_q <= win_d;
		end
	end

	// Window timer restarts on every opening
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			winCnt_q <= '0;
		end else if (ce) begin
			if (win_q == WIN_IDLE || win_d == WIN_IDLE) begin
				winCnt_q <= '0;
			end else begin
				winCnt_q <= winCnt_q + 1'b1;
			end
		end
	end

	// Closing a write window zeroes the subsecond counter
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			subsecondClear <= 1'b0;
		end else if (ce) begin
			subsecondClear <= (win_q == WIN_WRITE) && (win_d == WIN_IDLE);
		end
	end

	assign todReadEnable       = (win_q == WIN_READ);
	assign todWriteEnable      = (win_q == WIN_WRITE);
	assign todOscillatorEnable = todOscillatorEnable_q;

	// Clock-alarm bits vanish on variants without the clock
	assign enableView = {extIntEnable_q[5] & todPresent_q, extIntEnable_q[4:0]};
	assign priorityView = {extIntPriority_q[5] & todPresent_q, extIntPriority_q[4:0]};

	assign rawReq = {todIrqFlag_q, watchdogIrqReq, pinSync_q[3:0]};

	// One gate per source: clock alarm, watchdog, pins 5..2
	genvar s;
	generate
		for (s = 0; s < `TODAI_NUM_SRC; s++) begin : g_src
			assign gatedReq[s] = rawReq[s] & enableView[s];
			assign highReq[s]  = gatedReq[s] & priorityView[s];
			assign lowReq[s]   = gatedReq[s] & !priorityView[s];
		end
	endgenerate

	// Any high request wins; within a level the higher bit goes first
	always_comb begin
		irq_d = '0;
		irq_d.pending = |gatedReq;
		if (|highReq) begin
			irq_d.highPrio = 1'b1;
			for (int i = 0; i < `TODAI_NUM_SRC; i++) begin
				if (highReq[i]) begin
					irq_d.source = 3'(i);
				end
			end
		end else begin
			for (int i = 0; i < `TODAI_NUM_SRC; i++) begin
				if (lowReq[i]) begin
					irq_d.source = 3'(i);
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irqOut <= '0;
		end else if (ce) begin
			irqOut <= irq_d;
		end
	end

	assign ctlView = {compareEnable_q, todReadEnable, todWriteEnable,
		todIrqFlag_q, todOscillatorEnable_q};

	// Read mux; reserved bits read 0 (undefined bits of the enable register too)
	always_comb begin
		rdData_d = 8'h00;
		rdHit_d  = 1'b1;
		case (sfrAddr)
			`TODAI_ADDR_EXT_INT_ENABLE: begin
				rdData_d = {2'h0, enableView};
			end
			`TODAI_ADDR_EXT_INT_PRIORITY: begin
				rdData_d = {2'h0, priorityView};
			end
			`TODAI_ADDR_ALARM_SUBSECOND: begin
				rdData_d = alarmSubsecond_q;
			end
			`TODAI_ADDR_ALARM_SECOND: begin
				rdData_d = {2'h0, alarmSecond_q};
			end
			`TODAI_ADDR_ALARM_MINUTE: begin
				rdData_d = {2'h0, alarmMinute_q};
			end
			`TODAI_ADDR_ALARM_HOUR: begin
				rdData_d = {3'h0, alarmHour_q};
			end
			`TODAI_ADDR_TIME_OF_DAY_CONTROL: begin
				rdData_d = ctlView;
			end
			default: begin
				rdHit_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sfrRdData <= 8'h00;
			sfrRdHit  <= 1'b0;
		end else if (ce) begin
			sfrRdHit <= sfrRdEn && rdHit_d;
			if (sfrRdEn) begin
				sfrRdData <= rdHit_d ? rdData_d : 8'h00;
			end
		end
	end

endmodule : todai_regs

`default_nettype wire

/* sim/todai_regs_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module todai_regs_properties
	import todai_pkg::*;
(
	input wire logic          clk,
	input wire logic          rst_n,
	input wire logic          batteryRst_n,
	input wire logic          ce,
	input wire logic [7:0]    sfrAddr,
	input wire logic          sfrWrEn,
	input wire logic [7:0]    sfrWrData,
	input wire logic          sfrRdEn,
	input wire logic [7:0]    sfrRdData,
	input wire logic          sfrRdHit,
	input wire logic          watchdogIrqReq,
	input wire todai_irq_type irqOut,
	input wire logic          todOscillatorEnable
);
	logic [5:0] eieQ;
	logic [5:0] eipQ;
	logic [5:0] eieP;
	logic [5:0] eipP;
	logic       mapped;

	assign mapped = sfrAddr inside {8'he8, 8'hf2, 8'hf3, 8'hf4, 8'hf5, 8'hf8, 8'hf9};

	// Shadows follow the write strobe so irqOut is judged from the ports alone
	always_ff @(posedge clk) begin
		if (ce && !rst_n) begin
			eieQ <= 6'h00;
			eipQ <= 6'h00;
		end else if (ce && sfrWrEn && sfrAddr == 8'he8) begin
			eieQ <= sfrWrData[5:0];
		end else if (ce && sfrWrEn && sfrAddr == 8'hf8) begin
			eipQ <= sfrWrData[5:0];
		end
	end

	// irqOut is registered, so it answers to the enables of one cycle earlier
	always_ff @(posedge clk) begin
		if (ce) begin
			eieP <= eieQ;
			eipP <= eipQ;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_rd_unmapped: assert property (sfrRdEn && ce && !mapped |=> !sfrRdHit && sfrRdData == 8'h00)
		else $error("unmapped read answered");
	chk_rd_mapped: assert property (sfrRdEn && ce && mapped |=> sfrRdHit)
		else $error("mapped read without hit");
	chk_hit_cause: assert property (sfrRdHit |-> $past(sfrRdEn && ce))
		else $error("read hit without a read");
	chk_upper_zero: assert property (
		sfrRdHit && $past(sfrAddr) inside {8'hf3, 8'hf4, 8'hf8} |-> sfrRdData[7:6] == 2'b00)
		else $error("unused upper bits not zero");
	chk_hour_upper: assert property (
		sfrRdHit && $past(sfrAddr) == 8'hf5 |-> sfrRdData[7:5] == 3'b000)
		else $error("hour alarm upper bits not zero");
	chk_irq_enabled: assert property (irqOut.pending |-> eieP[irqOut.source])
		else $error("disabled source shown");
	chk_irq_prio: assert property (
		irqOut.pending |-> irqOut.highPrio == eipP[irqOut.source])
		else $error("priority level wrong");
	chk_wd_high: assert property (
		watchdogIrqReq && ce && eieQ[4] && eipQ[4] && !eieQ[5]
		|=> irqOut.pending && irqOut.highPrio && irqOut.source == 3'd4)
		else $error("high watchdog request lost");
	chk_osc_keep: assert property (@(posedge clk) disable iff (!batteryRst_n)
		!rst_n && ce |=> $stable(todOscillatorEnable))
		else $error("device reset touched oscillator enable");
endmodule : todai_regs_properties

bind todai_regs todai_regs_properties u_props (
	.clk(clk), .rst_n(rst_n), .batteryRst_n(batteryRst_n), .ce(ce), .sfrAddr(sfrAddr),
	.sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
	.sfrRdHit(sfrRdHit), .watchdogIrqReq(watchdogIrqReq), .irqOut(irqOut),
	.todOscillatorEnable(todOscillatorEnable));
`default_nettype wire

/* sim/todai_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module todai_regs_tb
	import todai_pkg::*;
;
	localparam logic [7:0]  ADDR [6] = '{8'he8, 8'hf2, 8'hf3, 8'hf4, 8'hf5, 8'hf8};
	localparam logic [7:0]  IMPL [6] = '{8'h3f, 8'hff, 8'h3f, 8'h3f, 8'h1f, 8'h3f};
	localparam int          LIM  [6] = '{256, 256, 60, 60, 24, 256};
	localparam int          SH   [4] = '{20, 14, 8, 0};
	localparam logic [31:0] COR  [4] = '{32'h00011f1f, 32'h00101f10, 32'h00001f1f, 32'h0000001f};
	logic                clk;
	logic                rst_n;
	logic                batteryRst_n;
	logic                todPresent;
	logic [7:0]          sfrAddr;
	logic                sfrWrEn;
	logic [7:0]          sfrWrData;
	logic                sfrRdEn;
	logic [7:0]          sfrRdData;
	logic                sfrRdHit;
	logic                ce;
	logic                timedAccessOk;
	logic                todReadEnable;
	logic                todWriteEnable;
	logic                todOscillatorEnable;
	logic                subsecondClear;
	todai_tod_count_type todCount;
	todai_tod_count_type tc;
	logic                watchdogIrqReq;
	logic [3:0]          extIrqPin;
	todai_irq_type       irqOut;
	logic [7:0]          vals [6];
	logic [7:0]          ext_int_priority;
	logic [31:0]         r;
	int                  failures;
	int                  samples_checked;
	int                  seed;

	todai_regs #(.WIN_CYCLES(20)) u_todai_regs (
		.clk(clk), .rst_n(rst_n), .batteryRst_n(batteryRst_n), .ce(ce),
		.todPresent(todPresent), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData),
		.sfrRdEn(sfrRdEn), .timedAccessOk(timedAccessOk),
		.sfrRdData(sfrRdData), .sfrRdHit(sfrRdHit),
		.todCount(todCount), .watchdogIrqReq(watchdogIrqReq), .extIrqPin(extIrqPin),
		.irqOut(irqOut), .todReadEnable(todReadEnable), .todWriteEnable(todWriteEnable),
		.todOscillatorEnable(todOscillatorEnable), .subsecondClear(subsecondClear));

	always #2 clk = ~clk;

	function automatic logic [4:0] expIrq(input logic [5:0] req, input logic [5:0] pr);
		for (int lvl = 1; lvl >= 0; lvl--)
			for (int i = 5; i >= 0; i--)
				if (req[i] && pr[i] == lvl[0])
					return {1'b1, pr[i], i[2:0]};
		return 5'h00;
	endfunction : expIrq

	task automatic stop_test;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfrAddr = a;
		sfrWrData = d;
		sfrWrEn = 1'b1;
		@(negedge clk);
		sfrWrEn = 1'b0;
	endtask : wr

	// Only e9 is used as the unmapped probe, so the hit is known from the address
	task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		@(negedge clk);
		sfrAddr = a;
		sfrRdEn = 1'b1;
		@(negedge clk);
		sfrRdEn = 1'b0;
		chk({sfrRdHit, sfrRdData & m}, {a != 8'he9, e & m});
	endtask : rd

	// Pins need two cycles through the synchroniser and one into irqOut, so five is safe for every source
	task automatic irq(input logic [4:0] e);
		repeat (5) @(negedge clk);
		chk({4'h0, irqOut}, {4'h0, e});
	endtask : irq

	// Oscillator enable, read window, write window and subsecond clear as one nibble
	task automatic win(input logic [8:0] e);
		chk({5'h0, todOscillatorEnable, todReadEnable, todWriteEnable, subsecondClear}, e);
	endtask : win

	task automatic rst(input logic p);
		@(negedge clk);
		rst_n = 1'b0;
		todPresent = p;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
	endtask : rst

	initial begin
		#40000;
		failures++;
		stop_test();
	end

	initial begin
		seed = 32'h7474;
		failures = 0;
		samples_checked = 0;
		clk = 1'b0;
		rst_n = 1'b0;
		batteryRst_n = 1'b0;
		todPresent = 1'b1;
		sfrAddr = 8'h00;
		sfrWrEn = 1'b0;
		sfrWrData = 8'h00;
		sfrRdEn = 1'b0;
		ce = 1'b1;
		timedAccessOk = 1'b0;
		todCount = '0;
		watchdogIrqReq = 1'b0;
		extIrqPin = 4'h0;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		batteryRst_n = 1'b1;
		for (int i = 0; i < 6; i++) begin
			vals[i] = 8'($unsigned($random(seed)) % LIM[i]);
			wr(ADDR[i], vals[i]);
			rd(ADDR[i], i == 0 ? 8'h3f : 8'hff, vals[i] & IMPL[i]);
		end
		wr(8'hf8, 8'hff);
		rd(8'hf8, 8'hff, 8'h3f);
		rd(8'he9, 8'hff, 8'h00);
		rst(1'b1);
		for (int i = 0; i < 6; i++)
			rd(ADDR[i], i == 0 ? 8'h3f : 8'hff, (i == 0 || i == 5) ? 8'h00 : vals[i] & IMPL[i]);
		for (int n = 0; n < 14; n++) begin
			r = (n < 4) ? COR[n] : $random(seed);
			extIrqPin = r[3:0];
			watchdogIrqReq = r[4];
			wr(8'he8, r[15:8]);
			wr(8'hf8, r[23:16]);
			irq(expIrq({1'b0, r[4:0]} & r[13:8], r[21:16]));
		end
		extIrqPin = 4'h0;
		watchdogIrqReq = 1'b0;
		tc = {vals[1], vals[2][5:0], vals[3][5:0], 3'b101, vals[4][4:0]};
		ext_int_priority = $random(seed);
		wr(8'hf8, ext_int_priority);
		for (int f = 0; f < 4; f++) begin
			todCount = tc ^ (28'h1 << SH[f]);
			wr(8'he8, 8'h20);
			wr(8'hf9, 8'hf0);
			irq(5'h00);
			wr(8'hf9, 8'hf0 & ~(8'h80 >> f));
			irq({1'b1, ext_int_priority[5], 3'd5});
			rd(8'hf9, 8'hf2, 8'hf2 & ~(8'h80 >> f));
			wr(8'he8, 8'h00);
			irq(5'h00);
			wr(8'hf9, 8'h00);
			rd(8'hf9, 8'hff, 8'h00);
		end
		// Read window stays open for exactly WIN_CYCLES edges
		wr(8'hf9, 8'h08);
		rd(8'hf9, 8'h0d, 8'h08);
		repeat (17) @(negedge clk);
		win(9'h004);
		@(negedge clk);
		win(9'h000);
		wr(8'hf9, 8'h0c);
		win(9'h000);
		timedAccessOk = 1'b1;
		wr(8'hf9, 8'h05);
		timedAccessOk = 1'b0;
		win(9'h00a);
		wr(8'hf9, 8'h00);
		rd(8'hf9, 8'h0d, 8'h05);
		timedAccessOk = 1'b1;
		wr(8'hf9, 8'h01);
		timedAccessOk = 1'b0;
		win(9'h009);
		@(negedge clk);
		win(9'h008);
		rst(1'b0);
		rd(8'hf9, 8'h0d, 8'h01);
		wr(8'he8, 8'hff);
		rd(8'he8, 8'h3f, 8'h1f);
		wr(8'hf8, 8'hff);
		rd(8'hf8, 8'hff, 8'h1f);
		// Let the read hit drop before freezing, so the frozen hit is not stale
		@(negedge clk);
		ce = 1'b0;
		wr(8'he8, 8'h00);
		ce = 1'b1;
		rd(8'he8, 8'h3f, 8'h1f);
		stop_test();
	end
endmodule : todai_regs_tb
`default_nettype wire
